// >>> omc_defs.vh
/*
 operating-mode controller constants: mode codes, context widths, register file layout.
 assumes inclusion by bare name from the design files.
*/
`ifndef OMC_DEFS_VH
`define OMC_DEFS_VH

// ----------------------------------------
// basic modes
// ----------------------------------------
`define OMC_MODE_W        2
`define OMC_MODE_REAL     2'h0
`define OMC_MODE_PROT     2'h1
`define OMC_MODE_MGMT     2'h2
`define OMC_MODE_NONE     2'h3

// ----------------------------------------
// register file
// ----------------------------------------
`define OMC_REG_W         32
`define OMC_REG_CNT       8
`define OMC_REG_IDX_W     3
`define OMC_RST_VAL       32'h00000000

// access sizes
`define OMC_SIZE_W        2
`define OMC_SIZE_B_LO     2'h0
`define OMC_SIZE_B_HI     2'h1
`define OMC_SIZE_HALF     2'h2
`define OMC_SIZE_WORD     2'h3

// ----------------------------------------
// address space select
// ----------------------------------------
`define OMC_SPACE_NORMAL  1'h0
`define OMC_SPACE_MGMT    1'h1

`endif

// >>> omc_reg_file.v
/*
 general register file: eight 32-bit registers, each reachable as low byte,
 second byte, low half or whole word.
 assumes write requests come from logic on ref_clk.
*/
`timescale 1ns/1ps
`include "omc_defs.vh"

module omc_reg_file (
	input  wire                      ref_clk,
	input  wire                      srst,
	input  wire                      wr_en,
	input  wire [`OMC_REG_IDX_W-1:0] wr_idx,
	input  wire [`OMC_SIZE_W-1:0]    wr_size,
	input  wire [`OMC_REG_W-1:0]     wr_data,
	input  wire [`OMC_REG_IDX_W-1:0] rd_idx,
	input  wire [`OMC_SIZE_W-1:0]    rd_size,
	output reg  [`OMC_REG_W-1:0]     rd_data
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	reg [`OMC_REG_W-1:0] general_reg [0:`OMC_REG_CNT-1];

	// merge a sized write into a whole word
	function [`OMC_REG_W-1:0] merge;
		input [`OMC_REG_W-1:0]  old;
		input [`OMC_SIZE_W-1:0] size;
		input [`OMC_REG_W-1:0]  val;
		begin
			case (size)
				`OMC_SIZE_B_LO: merge = {old[31:8], val[7:0]};
				`OMC_SIZE_B_HI: merge = {old[31:16], val[7:0], old[7:0]};
				`OMC_SIZE_HALF: merge = {old[31:16], val[15:0]};
				default:        merge = val;
			endcase
		end
	endfunction

	// extract a sized read, zero above
	function [`OMC_REG_W-1:0] pick;
		input [`OMC_REG_W-1:0]  word;
		input [`OMC_SIZE_W-1:0] size;
		begin
			case (size)
				`OMC_SIZE_B_LO: pick = {24'h000000, word[7:0]};
				`OMC_SIZE_B_HI: pick = {24'h000000, word[15:8]};
				`OMC_SIZE_HALF: pick = {16'h0000, word[15:0]};
				default:        pick = word;
			endcase
		end
	endfunction

	// per-register write, same in every mode
	genvar gi;
	generate
		for (gi = 0; gi < `OMC_REG_CNT; gi = gi + 1) begin : g_reg
			always @(posedge ref_clk) begin
				if (srst) begin
					general_reg[gi] <= `OMC_RST_VAL;
				end else if (wr_en && ({{(32-`OMC_REG_IDX_W){1'b0}}, wr_idx} == gi)) begin
					general_reg[gi] <= merge(general_reg[gi], wr_size, wr_data); // [RULE8]
				end
			end
		end
	endgenerate

	// registered sized read
	always @(posedge ref_clk) begin
		if (srst) begin
			rd_data <= `OMC_RST_VAL;
		end else begin
			rd_data <= pick(general_reg[rd_idx], rd_size); // [RULE8]
		end
	end

endmodule

// >>> omc_mode_ctrl.v
/*
 operating-mode controller: tracks real, protected and management modes, per-task
 legacy attribute, management entry with context save and resume with restore.
 assumes mgmt_irq_pin_n is an asynchronous pin; all other inputs on ref_clk.
*/
// How it works
// RULE1: three basic modes; mode selects available instruction and feature sets.
// RULE2: reset always forces real-address mode.
// RULE3: low management pin enters the management state.
// RULE4: controller management message also enters the management state.
// RULE5: entry saves mode and task context, then switches address space.
// RULE6: resume restores saved mode and context exactly.
// RULE7: legacy execution is a task attribute, only effective in protected mode.
// RULE8: each general register accessible as byte, half or word, any mode.
// RULE9: only resume leaves management state; further interrupts ignored there.
`timescale 1ns/1ps
`include "omc_defs.vh"

module omc_mode_ctrl (
	input  wire                      ref_clk,
	input  wire                      srst,
	input  wire                      mgmt_irq_pin_n,
	input  wire                      prog_irq_msg,
	input  wire                      mgmt_resume,
	input  wire                      prot_enter,
	input  wire                      prot_leave,
	input  wire                      task_switch,
	input  wire                      task_legacy,
	input  wire [`OMC_REG_W-1:0]     task_ctx,
	input  wire                      reg_wr_en,
	input  wire [`OMC_REG_IDX_W-1:0] reg_wr_idx,
	input  wire [`OMC_SIZE_W-1:0]    reg_wr_size,
	input  wire [`OMC_REG_W-1:0]     reg_wr_data,
	input  wire [`OMC_REG_IDX_W-1:0] reg_rd_idx,
	input  wire [`OMC_SIZE_W-1:0]    reg_rd_size,
	output wire [`OMC_REG_W-1:0]     reg_rd_data,
	output reg  [`OMC_MODE_W-1:0]    mode,
	output reg                       system_mgmt_state,
	output reg                       legacy_active,
	output reg                       addr_space,
	output reg                       feat_protect,
	output reg                       feat_mgmt_ops,
	output reg  [`OMC_REG_W-1:0]     ctx_live,
	output reg                       mgmt_entry,
	output reg                       mgmt_exit
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [2:0] ST_REAL = 3'h1;
	localparam [2:0] ST_PROT = 3'h2;
	localparam [2:0] ST_MGMT = 3'h4;

	reg [2:0]            state;
	reg [2:0]            next_state;
	reg [2:0]            saved_state;
	reg                  saved_legacy;
	reg [`OMC_REG_W-1:0] saved_ctx;
	reg                  task_legacy_attr;
	reg                  pin_sync1;
	reg                  pin_sync2;
	reg                  pin_prev;
	wire                 mgmt_interrupt;
	wire                 enter_mgmt;
	wire                 leave_mgmt;

	// ----------------------------------------
	// state decoding
	// ----------------------------------------
	// true for the management state code
	function in_mgmt;
		input [2:0] st;
		begin
			in_mgmt = (st == ST_MGMT);
		end
	endfunction

	// one-hot state to the mode code shown outside
	function [`OMC_MODE_W-1:0] mode_code;
		input [2:0] st;
		begin
			case (st)
				ST_REAL: mode_code = `OMC_MODE_REAL; // [RULE1]
				ST_PROT: mode_code = `OMC_MODE_PROT; // [RULE1]
				ST_MGMT: mode_code = `OMC_MODE_MGMT; // [RULE1]
				default: mode_code = `OMC_MODE_NONE;
			endcase
		end
	endfunction

	// entry and resume strobes shared by save, restore and pulses
	assign enter_mgmt = ~in_mgmt(state) & in_mgmt(next_state);
	assign leave_mgmt = in_mgmt(state) & mgmt_resume; // [RULE9]

	// ----------------------------------------
	// pin synchroniser and edge detect
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			pin_sync1 <= 1'h1;
			pin_sync2 <= 1'h1;
			pin_prev  <= 1'h1;
		end else begin
			pin_sync1 <= mgmt_irq_pin_n;
			pin_sync2 <= pin_sync1;
			pin_prev  <= pin_sync2;
		end
	end

	// falling pin edge or controller message
	assign mgmt_interrupt = (pin_prev & ~pin_sync2)  // [RULE3]
		| prog_irq_msg;                              // [RULE4]

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_REAL: begin
				if (mgmt_interrupt) begin
					next_state = ST_MGMT;
				end else if (prot_enter) begin
					next_state = ST_PROT;
				end
			end
			ST_PROT: begin
				if (mgmt_interrupt) begin
					next_state = ST_MGMT;
				end else if (prot_leave) begin
					next_state = ST_REAL;
				end
			end
			ST_MGMT: begin
				// interrupts ignored, only resume leaves
				if (mgmt_resume) begin // [RULE9]
					next_state = saved_state; // [RULE6]
				end
			end
			default: next_state = ST_REAL;
		endcase
	end

	// ----------------------------------------
	// state, context save and restore
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			state            <= ST_REAL; // [RULE2]
			saved_state      <= ST_REAL;
			saved_legacy     <= 1'h0;
			saved_ctx        <= `OMC_RST_VAL;
			task_legacy_attr <= 1'h0;
			ctx_live         <= `OMC_RST_VAL;
			mgmt_entry       <= 1'h0;
			mgmt_exit        <= 1'h0;
		end else begin
			state      <= next_state;
			mgmt_entry <= 1'h0;
			mgmt_exit  <= 1'h0;
			if (enter_mgmt) begin
				saved_state  <= state; // [RULE5]
				saved_legacy <= task_legacy_attr; // [RULE5]
				saved_ctx    <= ctx_live; // [RULE5]
				mgmt_entry   <= 1'h1;
			end else if (leave_mgmt) begin
				task_legacy_attr <= saved_legacy; // [RULE6]
				ctx_live         <= saved_ctx; // [RULE6]
				mgmt_exit        <= 1'h1;
			end else if (!in_mgmt(state) && task_switch) begin
				task_legacy_attr <= task_legacy; // [RULE7]
				ctx_live         <= task_ctx;
			end
		end
	end

	// ----------------------------------------
	// mode outputs and feature gating
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			mode              <= `OMC_MODE_REAL;
			system_mgmt_state <= 1'h0;
			legacy_active     <= 1'h0;
			addr_space        <= `OMC_SPACE_NORMAL;
			feat_protect      <= 1'h0;
			feat_mgmt_ops     <= 1'h0;
		end else begin
			mode              <= mode_code(next_state); // [RULE1]
			system_mgmt_state <= in_mgmt(next_state);
			addr_space        <= in_mgmt(next_state) ? `OMC_SPACE_MGMT
				: `OMC_SPACE_NORMAL; // [RULE5]
			feat_protect      <= (next_state == ST_PROT); // [RULE1]
			feat_mgmt_ops     <= in_mgmt(next_state); // [RULE1]
			legacy_active     <= 1'h0;
			if (next_state == ST_PROT) begin
				// attribute effective only in protected mode
				if (in_mgmt(state)) begin
					legacy_active <= saved_legacy; // [RULE7]
				end else if (task_switch) begin
					legacy_active <= task_legacy; // [RULE7]
				end else begin
					legacy_active <= task_legacy_attr; // [RULE7]
				end
			end
		end
	end

	// ----------------------------------------
	// general registers
	// ----------------------------------------
	omc_reg_file u_regs (
		.ref_clk (ref_clk),
		.srst    (srst),
		.wr_en   (reg_wr_en),
		.wr_idx  (reg_wr_idx),
		.wr_size (reg_wr_size),
		.wr_data (reg_wr_data),
		.rd_idx  (reg_rd_idx),
		.rd_size (reg_rd_size),
		.rd_data (reg_rd_data)
	);

endmodule

// >>> omc_mode_ctrl_props.sv
/*
 checker for the operating-mode controller, bound to its top module.
 assumes one clock, ref_clk, and synchronous active-high srst.
*/
`timescale 1ns/1ps
`include "omc_defs.vh"

// ----------------------------------------
// port checker
// ----------------------------------------
module omc_props (
	input wire                   ref_clk,
	input wire                   srst,
	input wire                   mgmt_irq_pin_n,
	input wire                   prog_irq_msg,
	input wire                   mgmt_resume,
	input wire [`OMC_SIZE_W-1:0] reg_rd_size,
	input wire [`OMC_REG_W-1:0]  reg_rd_data,
	input wire [`OMC_MODE_W-1:0] mode,
	input wire                   system_mgmt_state,
	input wire                   legacy_active,
	input wire                   addr_space,
	input wire                   feat_protect,
	input wire                   feat_mgmt_ops,
	input wire [`OMC_REG_W-1:0]  ctx_live,
	input wire                   mgmt_entry,
	input wire                   mgmt_exit
);
	reg [`OMC_MODE_W-1:0] saved_mode;
	reg [`OMC_REG_W-1:0]  saved_ctx;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// mode and context held just before entry
	always @(posedge ref_clk) begin
		if (mgmt_entry) begin
			saved_mode <= $past(mode);
			saved_ctx  <= $past(ctx_live);
		end
	end
	rst_real_a: assert property (disable iff (1'h0) srst |=> mode == `OMC_MODE_REAL)
		else $error("mode not real after reset");
	msg_entry_a: assert property (prog_irq_msg && !system_mgmt_state |=>
		system_mgmt_state && mgmt_entry && mode == `OMC_MODE_MGMT) else $error("no entry on message");
	pin_entry_a: assert property ($fell(mgmt_irq_pin_n) && !system_mgmt_state |->
		##[1:6] system_mgmt_state) else $error("no entry on pin");
	mgmt_space_a: assert property (system_mgmt_state == (mode == `OMC_MODE_MGMT)
		&& addr_space == system_mgmt_state) else $error("space and mode disagree");
	mgmt_hold_a: assert property (system_mgmt_state && !mgmt_resume |=>
		system_mgmt_state && !mgmt_exit) else $error("left management without resume");
	resume_restore_a: assert property (system_mgmt_state && mgmt_resume |=>
		mgmt_exit && mode == saved_mode && ctx_live == saved_ctx) else $error("bad restore");
	legacy_prot_a: assert property (legacy_active |-> mode == `OMC_MODE_PROT)
		else $error("legacy outside protected");
	entry_pulse_a: assert property (mgmt_entry |-> $rose(system_mgmt_state) ##1 !mgmt_entry)
		else $error("entry pulse wrong");
	rd_zero_a: assert property (reg_rd_size == `OMC_SIZE_B_LO |=> reg_rd_data[31:8] == 24'h0)
		else $error("byte read not zero extended");
	feat_gate_a: assert property (feat_protect == (mode == `OMC_MODE_PROT)
		&& feat_mgmt_ops == system_mgmt_state) else $error("feature enables disagree with mode");
	mgmt_ignore_a: assert property (system_mgmt_state && prog_irq_msg |=> !mgmt_entry)
		else $error("entry repeated inside management");
endmodule

bind omc_mode_ctrl omc_props chk_u (.ref_clk, .srst, .mgmt_irq_pin_n, .prog_irq_msg,
	.mgmt_resume, .reg_rd_size, .reg_rd_data, .mode, .system_mgmt_state, .legacy_active,
	.addr_space, .feat_protect, .feat_mgmt_ops, .ctx_live, .mgmt_entry, .mgmt_exit);

// >>> omc_plat_irq.sv
/*
 platform interrupt logic model: management pin and controller message.
 assumes the pin has a pull-up and requests change at falling ref_clk.
*/
`timescale 1ns/1ps

module omc_plat_irq (
	input  wire ref_clk,
	output reg  mgmt_irq_pin_n,
	output reg  prog_irq_msg
);
	initial begin
		mgmt_irq_pin_n = 1'h1;
		prog_irq_msg = 1'h0;
	end
	// one-cycle controller message
	task send_msg;
		@(negedge ref_clk);
		prog_irq_msg = 1'h1;
		@(negedge ref_clk);
		prog_irq_msg = 1'h0;
	endtask
	// pin held low, then back to its pull-up level
	task pull_pin;
		@(negedge ref_clk);
		mgmt_irq_pin_n = 1'h0;
		repeat (6) @(negedge ref_clk);
		mgmt_irq_pin_n = 1'h1;
	endtask
endmodule

// >>> operating_mode_control_tb.sv
/*
 self-checking bench for the operating-mode controller.
 assumes a 10 MHz ref_clk and the platform interrupt model.
*/
`timescale 1ns/1ps
`include "omc_defs.vh"

module operating_mode_control_tb;
	reg         ref_clk, srst, mgmt_resume, prot_enter, prot_leave, task_switch;
	reg         task_legacy, reg_wr_en;
	reg  [31:0] task_ctx, reg_wr_data;
	reg  [2:0]  reg_wr_idx, reg_rd_idx;
	reg  [1:0]  reg_wr_size, reg_rd_size;
	wire [31:0] reg_rd_data, ctx_live;
	wire [1:0]  mode;
	wire        mgmt_irq_pin_n, prog_irq_msg, system_mgmt_state, legacy_active;
	wire        addr_space, mgmt_entry, mgmt_exit, feat_protect, feat_mgmt_ops;
	integer     num_errors = 0;
	integer     n_compared = 0;

	omc_plat_irq plat_u (.ref_clk, .mgmt_irq_pin_n, .prog_irq_msg);
	omc_mode_ctrl dut_u (.ref_clk, .srst, .mgmt_irq_pin_n, .prog_irq_msg, .mgmt_resume,
		.prot_enter, .prot_leave, .task_switch, .task_legacy, .task_ctx, .reg_wr_en,
		.reg_wr_idx, .reg_wr_size, .reg_wr_data, .reg_rd_idx, .reg_rd_size, .reg_rd_data,
		.mode, .system_mgmt_state, .legacy_active, .addr_space, .feat_protect,
		.feat_mgmt_ops, .ctx_live, .mgmt_entry, .mgmt_exit);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input string name, input [31:0] seen, input [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task final_report;
		if (num_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one-cycle pulse on {switch, resume, leave, enter}
	task pulse(input [3:0] p);
		@(negedge ref_clk);
		{task_switch, mgmt_resume, prot_leave, prot_enter} = p;
		@(negedge ref_clk);
		{task_switch, mgmt_resume, prot_leave, prot_enter} = 4'h0;
	endtask
	task wr(input [1:0] s, input [31:0] d);
		@(negedge ref_clk);
		{reg_wr_en, reg_wr_idx, reg_wr_size, reg_wr_data} = {1'h1, 3'h5, s, d};
		@(negedge ref_clk);
		reg_wr_en = 1'h0;
	endtask
	task rd(input [1:0] s, input [31:0] exp);
		{reg_rd_idx, reg_rd_size} = {3'h5, s};
		@(negedge ref_clk);
		chk("reg", reg_rd_data, exp);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// message entry from protected, ignored requests, restore
	task t_msg;
		pulse(4'h1);
		{task_legacy, task_ctx} = {1'h1, 32'h5A5A0F0F};
		pulse(4'h8);
		chk("legacy", legacy_active, 1'h1);
		plat_u.send_msg;
		chk("mode", mode, `OMC_MODE_MGMT);
		chk("space", addr_space, `OMC_SPACE_MGMT);
		chk("entry", mgmt_entry, 1'h1);
		chk("legacy", legacy_active, 1'h0);
		chk("mgmt_ops", feat_mgmt_ops, 1'h1);
		chk("protect", feat_protect, 1'h0);
		{task_legacy, task_ctx} = {1'h0, 32'h0};
		plat_u.send_msg;
		pulse(4'hA);
		chk("held", mode, `OMC_MODE_MGMT);
		pulse(4'h4);
		chk("mode", mode, `OMC_MODE_PROT);
		chk("ctx", ctx_live, 32'h5A5A0F0F);
		chk("legacy", legacy_active, 1'h1);
		chk("exit", mgmt_exit, 1'h1);
		chk("mgmt_ops", feat_mgmt_ops, 1'h0);
		chk("protect", feat_protect, 1'h1);
	endtask
	// reset in protected mode, then in management mode
	task t_reset;
		integer i;
		for (i = 0; i < 2; i = i + 1) begin
			if (i == 1) begin
				plat_u.send_msg;
			end
			@(negedge ref_clk);
			srst = 1'h1;
			@(negedge ref_clk);
			srst = 1'h0;
			chk("mode", mode, `OMC_MODE_REAL);
			chk("state", system_mgmt_state, 1'h0);
			chk("space", addr_space, `OMC_SPACE_NORMAL);
			chk("legacy", legacy_active, 1'h0);
			chk("ctx", ctx_live, 32'h0);
		end
	endtask
	// pin entry from real, resume back to real
	task t_pin;
		plat_u.pull_pin;
		chk("mode", mode, `OMC_MODE_MGMT);
		wr(`OMC_SIZE_WORD, 32'h13579BDF);
		rd(`OMC_SIZE_WORD, 32'h13579BDF);
		pulse(4'h4);
		chk("mode", mode, `OMC_MODE_REAL);
		chk("space", addr_space, `OMC_SPACE_NORMAL);
		pulse(4'h1);
		chk("mode", mode, `OMC_MODE_PROT);
		chk("protect", feat_protect, 1'h1);
		pulse(4'h2);
		chk("mode", mode, `OMC_MODE_REAL);
		chk("protect", feat_protect, 1'h0);
	endtask
	// merge of sizes in one register
	task t_regs;
		wr(`OMC_SIZE_WORD, 32'hA1B2C3D4);
		wr(`OMC_SIZE_B_LO, 32'h000000E7);
		rd(`OMC_SIZE_B_LO, 32'h000000E7);
		rd(`OMC_SIZE_B_HI, 32'h000000C3);
		rd(`OMC_SIZE_HALF, 32'h0000C3E7);
		rd(`OMC_SIZE_WORD, 32'hA1B2C3E7);
		wr(`OMC_SIZE_B_HI, 32'hFFFFFF5C);
		rd(`OMC_SIZE_B_HI, 32'h0000005C);
		rd(`OMC_SIZE_WORD, 32'hA1B25CE7);
		wr(`OMC_SIZE_HALF, 32'hFFFF1234);
		rd(`OMC_SIZE_HALF, 32'h00001234);
		rd(`OMC_SIZE_WORD, 32'hA1B21234);
	endtask

	// ----------------------------------------
	// clock, sequence, watchdog
	// ----------------------------------------
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		{srst, mgmt_resume, prot_enter, prot_leave, task_switch, task_legacy} = 6'h20;
		{task_ctx, reg_wr_en, reg_wr_idx, reg_wr_size, reg_wr_data} = 70'h0;
		{reg_rd_idx, reg_rd_size} = 5'h0;
		repeat (10) @(negedge ref_clk);
		srst = 1'h0;
		chk("mode", mode, `OMC_MODE_REAL);
		t_msg;
		t_reset;
		t_pin;
		t_regs;
		final_report;
	end
	initial begin
		#500000;
		num_errors++;
		final_report;
	end
endmodule
